// File: design/icc_input_capture.sv
// input-capture configuration for channels one and two: mode and
// enable registers, input mapping, digital filter and event divider
// assumes pins arrive asynchronous, trigger logic is on clk
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "icc_map.svh"
module icc_input_capture #(
    parameter int DTS_DIV = `ICC_DTS_DIV
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire icc_pkg::icc_bus_type   busReq,
    output logic [`ICC_DATA_W-1:0]      busRdata,
    input  wire logic                   timerInputOne,
    input  wire logic                   timerInputTwo,
    input  wire logic                   internalTriggerSignal,
    input  wire logic                   trigSrcInternal,
    output logic [1:0]                  capEvent,
    output logic [1:0]                  captureLevel,
    output logic [1:0]                  chanIsInput
);
    initial begin
        if (DTS_DIV < 1 || DTS_DIV > 256) begin
            $error("DTS_DIV must lie in 1..256");
        end
    end

    ////////////////////////////////////////////////////////////////
    // registers and port
    logic [15:0] modeR_r;
    logic [1:0]  chanEn_r;
    logic [15:0] rdata_r;
    logic [15:0] modeNxt;
    logic [15:0] statWord;
    logic [15:0] rdNxt;
    logic        selMode;
    logic        selEn;
    logic        selStat;
    logic [2:0]  pscCnt_r [2];
    logic [1:0]  lvl_r;
    logic [1:0]  lvlD_r;
    logic [1:0]  capEv_r;
    logic [1:0]  src;

    assign selMode = busReq.addr == `ICC_MODE_OFS;
    assign selEn   = busReq.addr == `ICC_EN_OFS;
    assign selStat = busReq.addr == `ICC_STAT_OFS;

    // selection bits keep their value while their channel runs
    assign modeNxt = {busReq.wdata[15:10],
                      chanEn_r[1] ? modeR_r[9:8] : busReq.wdata[9:8],
                      busReq.wdata[7:2],
                      chanEn_r[0] ? modeR_r[1:0] : busReq.wdata[1:0]};

    assign statWord = {5'h00, pscCnt_r[1], 1'b0, pscCnt_r[0],
                       2'h0, lvl_r};
    assign rdNxt = selMode ? modeR_r :
                   selEn   ? {14'h0000, chanEn_r} :
                   selStat ? statWord : 16'h0000;

    // register writes; reads answer one cycle later, unmapped as zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            modeR_r  <= `ICC_MODE_RST;
            chanEn_r <= `ICC_EN_RST;
            rdata_r  <= 16'h0000;
        end else begin
            if (busReq.wr && selMode) begin
                modeR_r <= modeNxt;
            end
            if (busReq.wr && selEn) begin
                chanEn_r <= busReq.wdata[1:0];
            end
            rdata_r <= busReq.rd ? rdNxt : 16'h0000;
        end
    end
    assign busRdata = rdata_r;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers and dead-time sample tick
    logic [1:0] tinM_r;
    logic [1:0] tinS_r;
    logic [7:0] dtsCnt_r;
    logic [4:0] divCnt_r;
    logic       dtsTick;
    logic [6:0] ticks;

    // dead-time rate is a tick derived from clk, not a second clock
    assign dtsTick = dtsCnt_r == 8'(DTS_DIV - 1);
    assign ticks = {dtsTick & (&divCnt_r[4:0]), dtsTick & (&divCnt_r[3:0]),
                    dtsTick & (&divCnt_r[2:0]), dtsTick & (&divCnt_r[1:0]),
                    dtsTick & divCnt_r[0], dtsTick, 1'b1};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tinM_r   <= 2'h0;
            tinS_r   <= 2'h0;
            dtsCnt_r <= 8'h00;
            divCnt_r <= 5'h00;
        end else begin
            tinM_r   <= {timerInputTwo, timerInputOne};
            tinS_r   <= tinM_r;
            dtsCnt_r <= dtsTick ? 8'h00 : dtsCnt_r + 8'h01;
            divCnt_r <= dtsTick ? divCnt_r + 5'h01 : divCnt_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // filter code decode: sample tick and agreeing-sample count
    function automatic logic [2:0] tickSel(input logic [3:0] c);
        logic [2:0] t;
        t = 3'h0;
        unique case (c)
            4'h0:                   t = 3'h1;
            4'h1, 4'h2, 4'h3:       t = 3'h0;
            4'h4, 4'h5:             t = 3'h2;
            4'h6, 4'h7:             t = 3'h3;
            4'h8, 4'h9:             t = 3'h4;
            4'hA, 4'hB, 4'hC:       t = 3'h5;
            4'hD, 4'hE, 4'hF:       t = 3'h6;
        endcase
        return t;
    endfunction

    function automatic logic [3:0] needN(input logic [3:0] c);
        logic [3:0] n;
        n = 4'h1;
        unique case (c)
            4'h0:                   n = 4'h1;
            4'h1:                   n = 4'h2;
            4'h2:                   n = 4'h4;
            4'h3, 4'h5, 4'h7, 4'h9: n = 4'h8;
            4'h4, 4'h6, 4'h8:       n = 4'h6;
            4'hA, 4'hD:             n = 4'h5;
            4'hB, 4'hE:             n = 4'h6;
            4'hC, 4'hF:             n = 4'h8;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////
    // per-channel mapping, filter, edge and divider; channel two
    // uses the same encodings with its own enable
    logic [1:0] tick;
    logic [1:0] rise;
    logic [1:0] capNow;
    logic [3:0] fCnt_r [2];

    for (genvar i = 0; i < 2; i++) begin : g_ch
        icc_pkg::icc_chan_cfg_type cfg;
        logic [3:0] n;
        logic [2:0] ratioMax;
        logic       own;
        logic       nbr;
        logic       hit;

        assign cfg = modeR_r[i*`ICC_CH_STRIDE +: 8];
        assign own = tinS_r[i];
        assign nbr = tinS_r[1-i];
        assign chanIsInput[i] = cfg.sel != icc_pkg::ICC_SEL_OUT;

        // trigger mapping only passes while an internal source is picked
        assign src[i] = (cfg.sel == icc_pkg::ICC_SEL_OWN) ? own :
                        (cfg.sel == icc_pkg::ICC_SEL_NBR) ? nbr :
                        (cfg.sel == icc_pkg::ICC_SEL_TRG) ?
                            (trigSrcInternal & internalTriggerSignal) :
                        1'b0;
        assign tick[i] = ticks[tickSel(cfg.filt)];
        assign n = needN(cfg.filt);
        assign hit = fCnt_r[i] + 4'h1 >= n;
        assign rise[i] = lvl_r[i] & ~lvlD_r[i] & chanIsInput[i];
        assign ratioMax = 3'((4'h1 << cfg.div) - 4'h1);
        assign capNow[i] = rise[i] & chanEn_r[i] & (pscCnt_r[i] == ratioMax);

        // filter counter: a disagreeing sample counts, an agreeing one clears
        always_ff @(posedge clk) begin
            if (!rstn) begin
                fCnt_r[i] <= 4'h0;
                lvl_r[i]  <= 1'b0;
            end else if (tick[i]) begin
                if (src[i] == lvl_r[i]) begin
                    fCnt_r[i] <= 4'h0;
                end else if (hit) begin
                    fCnt_r[i] <= 4'h0;
                    lvl_r[i]  <= src[i];
                end else begin
                    fCnt_r[i] <= fCnt_r[i] + 4'h1;
                end
            end
        end

        // divider is held at zero while the channel is off
        always_ff @(posedge clk) begin
            if (!rstn || !chanEn_r[i]) begin
                pscCnt_r[i] <= 3'h0;
                lvlD_r[i]   <= 1'b0;
                capEv_r[i]  <= 1'b0;
            end else begin
                lvlD_r[i]  <= lvl_r[i];
                capEv_r[i] <= capNow[i];
                if (rise[i]) begin
                    pscCnt_r[i] <= capNow[i] ? 3'h0 : pscCnt_r[i] + 3'h1;
                end
            end
        end
    end

    assign capEvent     = capEv_r;
    assign captureLevel = lvl_r;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_sel1_write_lock: assert property (busReq.wr && selMode && chanEn_r[0]
        |=> $stable(modeR_r[1:0])) else $error("ch1 select changed");
    a_sel2_write_lock: assert property (busReq.wr && selMode && chanEn_r[1]
        |=> $stable(modeR_r[9:8])) else $error("ch2 select changed");
    a_out_no_capture: assert property ((modeR_r[1:0] == 2'h0) [*2]
        |-> !capEvent[0]) else $error("output channel captured");
    a_map_ch_one: assert property ((modeR_r[1:0] == 2'h1 |-> src[0] == tinS_r[0])
        and (modeR_r[1:0] == 2'h2 |-> src[0] == tinS_r[1]))
        else $error("ch1 mapping wrong");
    a_trg_ch_one: assert property (modeR_r[1:0] == 2'h3 && !trigSrcInternal
        |-> !src[0]) else $error("ch1 trigger leaks");
    a_map_ch_two: assert property ((modeR_r[9:8] == 2'h1 |-> src[1] == tinS_r[1])
        and (modeR_r[9:8] == 2'h2 |-> src[1] == tinS_r[0]))
        else $error("ch2 mapping wrong");
    a_trg_ch_two: assert property (modeR_r[9:8] == 2'h3
        |-> src[1] == (trigSrcInternal & internalTriggerSignal))
        else $error("ch2 trigger wrong");
    a_flip_on_tick: assert property ($changed(lvl_r[0]) |-> $past(tick[0]))
        else $error("filter flipped off tick");
    a_nofilt_follow: assert property (modeR_r[7:4] == 4'h0 && tick[0]
        && src[0] != lvl_r[0] |=> lvl_r[0] == $past(src[0]))
        else $error("unfiltered level lags");
    a_two_samples: assert property ((modeR_r[7:4] == 4'h1) [*3] ##0
        $changed(lvl_r[0]) |-> $past(src[0]) == lvl_r[0]
        && $past(src[0], 2) == lvl_r[0]) else $error("N=2 broken");
    // a code change right after a tick may legally speed the tick up
    a_div2_rate: assert property (modeR_r[7:4] == 4'h4 && tick[0]
        |=> !tick[0] || modeR_r[7:4] != 4'h4) else $error("div2 tick too fast");
    a_div32_rate: assert property (modeR_r[7:4] == 4'hF && tick[0]
        |=> (!tick[0] || modeR_r[7:4] != 4'hF) [*8])
        else $error("div32 tick too fast");
    a_psc_skip: assert property (chanEn_r[0] && modeR_r[3:2] == 2'h1
        && rise[0] && pscCnt_r[0] == 3'h0 |=> !capEvent[0])
        else $error("div2 captured early");
    a_psc_cleared: assert property (!chanEn_r[0] |=> pscCnt_r[0] == 3'h0)
        else $error("ch1 divider not held");

    c_cap_one: cover property (capEvent[0]);
    c_cap_div8: cover property (modeR_r[3:2] == 2'h3 && capEvent[0]);
    c_sel_blocked: cover property (busReq.wr && selMode && chanEn_r[0]);
    c_trg_cap: cover property (modeR_r[9:8] == 2'h3 && capEvent[1]);
endmodule

// File: design/icc_map.svh
// register map, field positions, reset values and timing of the
// channel one/two input-capture configuration block
// assumes a 16-bit register port and one 50 MHz timer clock
// Function
// - selection 00 makes channel one an output
// - channel one 01 own input, 10 neighbour
// - channel one 11 internal trigger, if selected
// - channel two 01 own input, 10 neighbour
// - channel two 11 internal trigger, if selected
// - channel one selection writable only while disabled
// - channel two selection writable only while disabled
// - filter flips after N agreeing samples
// - filter code 0000 unfiltered, dead-time rate
// - codes 0001-0011 timer clock, N 2/4/8
// - codes 0100-1001 dead-time /2,/4,/8, N 6/8
// - codes 1010-1111 /16,/32, N 5/6/8
// - divider captures every 1,2,4,8 events
// - channel one divider reset while disabled
// - channel one filter conditions its input
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH
`define ICC_ADDR_W     8
`define ICC_DATA_W     16
`define ICC_MODE_OFS   8'h00
`define ICC_EN_OFS     8'h04
`define ICC_STAT_OFS   8'h08
`define ICC_MODE_RST   16'h0000
`define ICC_EN_RST     2'h0
`define ICC_CH_STRIDE  8
`define ICC_SEL_LSB    0
`define ICC_PSC_LSB    2
`define ICC_FLT_LSB    4
`define ICC_STAT_CNT2  8
`define ICC_STAT_CNT1  4
`define ICC_CLK_MHZ    50
`define ICC_DTS_DIV    1
`endif

// File: design/icc_pkg.sv
// types shared by the input-capture configuration block
// assumes icc_map.svh supplies widths
`include "icc_map.svh"
package icc_pkg;
    // one channel's configuration byte
    typedef struct packed {
        logic [3:0] filt;
        logic [1:0] div;
        logic [1:0] sel;
    } icc_chan_cfg_type;
    // register port request
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [`ICC_ADDR_W-1:0] addr;
        logic [`ICC_DATA_W-1:0] wdata;
    } icc_bus_type;
    // direction/mapping codes
    typedef enum logic [1:0] {
        ICC_SEL_OUT = 2'h0,
        ICC_SEL_OWN = 2'h1,
        ICC_SEL_NBR = 2'h2,
        ICC_SEL_TRG = 2'h3
    } icc_sel_type;
endpackage

// File: sim/icc_pin_model.sv
// far-side model: timer input pins and trigger selection logic
// assumes the bench commands levels; the model moves them after clk rises
`timescale 1ns/1ps
module icc_pin_model (
    input  wire logic       clk,
    input  wire logic [2:0] level,
    input  wire logic       srcInternal,
    output logic            pinOne = 1'b0,
    output logic            pinTwo = 1'b0,
    output logic            trigLevel = 1'b0,
    output logic            trigInternal = 1'b1
);
    // registered so trigger and selector stay on clk, as the real selector does
    always @(posedge clk) begin
        pinOne <= level[0];
        pinTwo <= level[1];
        trigLevel <= level[2];
        trigInternal <= srcInternal;
    end
endmodule

// File: sim/input_capture_config_ch1_ch2_test.sv
// self-checking bench for the channel one/two capture configuration block
// assumes icc_pin_model drives the pins and the register port answers in one cycle
`timescale 1ns/1ps
module input_capture_config_ch1_ch2_test;
    logic                 clk = 1'b0;
    logic                 rstn = 1'b0;
    icc_pkg::icc_bus_type busReq = '0;
    logic [15:0]          busRdata;
    logic [2:0]           level = 3'h0;
    logic                 srcInternal = 1'b1;
    logic                 pinOne, pinTwo, trigLevel, trigInternal;
    logic [1:0]           capEvent, captureLevel, chanIsInput;
    logic [15:0]          cnt1 = 16'h0000, cnt2 = 16'h0000, base1, base2;
    int                   bad_count = 0, checked = 0, cycles = 0;
    logic [3:0]           fc [5] = '{4'h1, 4'h3, 4'h4, 4'hA, 4'hF};
    int                   shortHi [5] = '{1, 6, 8, 48, 200};

    icc_input_capture #(.DTS_DIV(1)) i_icc_input_capture (.clk(clk), .rstn(rstn),
        .busReq(busReq), .busRdata(busRdata), .timerInputOne(pinOne),
        .timerInputTwo(pinTwo), .internalTriggerSignal(trigLevel),
        .trigSrcInternal(trigInternal), .capEvent(capEvent),
        .captureLevel(captureLevel), .chanIsInput(chanIsInput));
    icc_pin_model i_icc_pin_model (.clk(clk), .level(level), .srcInternal(srcInternal),
        .pinOne(pinOne), .pinTwo(pinTwo), .trigLevel(trigLevel),
        .trigInternal(trigInternal));

    ////////////////////////////////////////////////////////////////////////
    // clock, capture counting and hang guard (whole run is near 5.6k cycles)
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rstn) begin
            cnt1 <= cnt1 + 16'(capEvent[0]);
            cnt2 <= cnt2 + 16'(capEvent[1]);
        end
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port and stimulus tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        busReq <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        busReq <= '0;
        #1 chk(what, exp, busRdata);
    endtask
    // disabling first keeps selections writable and clears the dividers
    task automatic cfg(input logic [15:0] mode);
        wr(8'h04, 16'h0000);
        wr(8'h00, mode);
        wr(8'h04, 16'h0003);
        #1 base1 = cnt1;
        base2 = cnt2;
    endtask
    task automatic pulse(input logic [2:0] m, input int hi, input int lo, input int n);
        repeat (n) begin
            @(posedge clk);
            level <= m;
            repeat (hi) @(posedge clk);
            level <= 3'h0;
            repeat (lo) @(posedge clk);
        end
    endtask
    task automatic caps(input logic [15:0] e1, input logic [15:0] e2);
        repeat (8) @(posedge clk);
        #1 chk("captures one", e1, cnt1 - base1);
        chk("captures two", e2, cnt2 - base2);
        base1 = cnt1;
        base2 = cnt2;
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h00, 16'h0000, "mode reset");
        rd(8'h0C, 16'h0000, "unmapped read");
        chk("direction", 16'h0000, {14'h0, chanIsInput});
        cfg(16'h0101);
        wr(8'h00, 16'hF6F6);
        rd(8'h00, 16'hF5F5, "mode locked");
        // output mode never captures
        cfg(16'h0000);
        chk("direction", 16'h0000, {14'h0, chanIsInput});
        pulse(3'h7, 6, 10, 1);
        caps(16'h0000, 16'h0000);
        // every mapping against every source
        for (int s = 1; s < 4; s++) begin
            cfg(16'(s * 257));
            for (int k = 0; k < 3; k++) begin
                pulse(3'(1 << k), 6, 10, 1);
                caps(16'(s == k + 1), 16'(k == (s == 3 ? 2 : 2 - s)));
            end
        end
        srcInternal <= 1'b0;
        cfg(16'h0303);
        chk("direction", 16'h0003, {14'h0, chanIsInput});
        pulse(3'h4, 6, 10, 1);
        caps(16'h0000, 16'h0000);
        srcInternal <= 1'b1;
        // a pulse shorter than N samples is rejected, a long one passes
        for (int i = 0; i < 5; i++) begin
            cfg({fc[i], 4'h1, fc[i], 4'h1});
            pulse(3'h3, shortHi[i], 300, 1);
            caps(16'h0000, 16'h0000);
            pulse(3'h3, 300, 300, 1);
            caps(16'h0001, 16'h0001);
        end
        for (int d = 0; d < 4; d++) begin
            cfg({4'h0, 2'(d), 2'h1, 4'h0, 2'(d), 2'h1});
            pulse(3'h3, 4, 4, 8);
            caps(16'(8 >> d), 16'(8 >> d));
        end
        // a disable in mid-count restarts the divider
        cfg(16'h0505);
        pulse(3'h3, 4, 4, 1);
        rd(8'h08, 16'h0110, "divider count");
        cfg(16'h0505);
        rd(8'h08, 16'h0000, "divider cleared");
        pulse(3'h3, 4, 4, 1);
        caps(16'h0000, 16'h0000);
        pulse(3'h3, 4, 4, 1);
        caps(16'h0001, 16'h0001);
        // a held level reaches the filtered output of both channels
        @(posedge clk);
        level <= 3'h3;
        repeat (8) @(posedge clk);
        #1 chk("filtered level", 16'h0003, {14'h0, captureLevel});
        end_of_test();
    end
endmodule
